/* File: logic/sarp_pkg.sv */
package sarp_pkg;
  // ------------------------------------------------------------
  // Result format
  // ------------------------------------------------------------
  localparam int result_width = 12;             // Converter resolution
  localparam logic [3:0] last_bit = 4'hb;       // Index of result MSB
  localparam logic [3:0] bit_count_reset = 4'h0; // Counter reset value
  localparam logic [11:0] result_reset = 12'h000; // Result reset value

  // ------------------------------------------------------------
  // Link timing
  // ------------------------------------------------------------
  localparam int clock_period_ns = 20;          // System clock period
  localparam int min_select_low_cycles = 14;    // Host keeps select low this long

  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    sarp_idle     = 6'h01,  // Select high, sampling, output off
    sarp_wait     = 6'h02,  // Select low, waiting for first clock pulse
    sarp_null     = 6'h04,  // Null bit, sample goes to hold
    sarp_msb      = 6'h08,  // Conversion and MSB-first shift
    sarp_lsb      = 6'h10,  // LSB-first repeat
    sarp_done     = 6'h20   // All bits sent, line low
  } sarp_state_type;
endpackage : sarp_pkg

/* File: logic/sarp_sync.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Two-stage synchroniser with edge detection on the second stage
// ------------------------------------------------------------
module sarp_sync (
  input wire logic clock,
  input wire logic reset,
  input wire logic async_in,
  input wire logic reset_value,
  output logic level,
  output logic rise,
  output logic fall
);
  logic stage_one; // Only read by level
  logic level_prev; // For edge finding

  // Two flip-flops before any logic looks at the pin
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stage_one <= 1'b0;
      level <= 1'b0;
      level_prev <= 1'b0;
    end else begin
      stage_one <= async_in;
      level <= stage_one;
      level_prev <= level;
    end
  end

  // Edges seen on the settled copy only
  assign rise = level & ~level_prev;
  assign fall = ~level & level_prev;

  // Reset value input kept for caller symmetry on select line
  logic unused_reset_value;
  assign unused_reset_value = reset_value;
endmodule : sarp_sync

/* File: logic/sarp_port.sv */
`timescale 1ns/1ps
// Summary of operation
// - Data output changes on shift clock falling edges
// - No configuration input; fixed unipolar differential input
// - First clock pulse after select low enables output
// - Null bit, MSB-first result, then LSB-first
// - Shifted result comes from this exchange's conversion
// - Select high resets sequencing for next exchange
// - Sampling spans select-high time plus half-cycle
// - Sample end: hold positive input, start conversion
// - Hold on falling edge; twelve cycles, bit per cycle
module sarp_port (
  input wire logic clock,
  input wire logic reset,
  input wire logic select_n,
  input wire logic shift_clock,
  input wire logic comparator_high,
  output logic data_out,
  output logic data_out_enable,
  output logic sample_enable,
  output logic hold,
  output logic negative_input_select,
  output logic [11:0] trial_code,
  output logic conversion_done
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic select_level; // Settled select
  logic select_rise; // Select deasserted
  logic select_fall; // Select asserted
  logic shift_level; // Settled shift clock
  logic shift_rise; // Shift clock rising
  logic shift_fall; // Shift clock falling

  sarp_sync select_sync (
    .clock(clock),
    .reset(reset),
    .async_in(~select_n),
    .reset_value(1'b0),
    .level(select_level),
    .rise(select_fall),
    .fall(select_rise)
  );

  sarp_sync shift_sync (
    .clock(clock),
    .reset(reset),
    .async_in(shift_clock),
    .reset_value(1'b0),
    .level(shift_level),
    .rise(shift_rise),
    .fall(shift_fall)
  );

  // ------------------------------------------------------------
  // Sequencer state
  // ------------------------------------------------------------
  sarp_pkg::sarp_state_type state; // Current phase
  sarp_pkg::sarp_state_type next_state; // Next phase
  logic [3:0] bit_index; // Bit under test or being shifted
  logic [11:0] result; // Successive approximation register
  logic [11:0] trial_bit; // One-hot weight of bit under test
  logic clock_seen; // A shift clock rise after select fell

  // Weight of bit under test, one entry per bit
  genvar g;
  generate
    for (g = 0; g < sarp_pkg::result_width; g++) begin : gen_weight
      assign trial_bit[g] = (bit_index == 4'(g));
    end
  endgenerate

  // No data input exists; fixed differential unipolar operation

  // Next-state decode
  always_comb begin
    next_state = state;
    case (state)
      sarp_pkg::sarp_idle: begin
        if (select_fall) begin
          next_state = sarp_pkg::sarp_wait;
        end
      end
      sarp_pkg::sarp_wait: begin
        // Sampling continues until the first falling edge after a rise
        if (clock_seen && shift_fall) begin
          next_state = sarp_pkg::sarp_null;
        end
      end
      sarp_pkg::sarp_null: begin
        if (shift_fall) begin
          next_state = sarp_pkg::sarp_msb;
        end
      end
      sarp_pkg::sarp_msb: begin
        if (shift_fall && bit_index == 4'h0) begin
          next_state = sarp_pkg::sarp_lsb;
        end
      end
      sarp_pkg::sarp_lsb: begin
        if (shift_fall && bit_index == sarp_pkg::last_bit) begin
          next_state = sarp_pkg::sarp_done;
        end
      end
      sarp_pkg::sarp_done: begin
        next_state = sarp_pkg::sarp_done;
      end
      default: begin
        next_state = sarp_pkg::sarp_idle;
      end
    endcase
    // Select high aborts any phase
    if (select_rise || !select_level) begin
      if (state != sarp_pkg::sarp_idle || !select_fall) begin
        next_state = sarp_pkg::sarp_idle;
      end
    end
  end

  // State register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= sarp_pkg::sarp_idle;
    end else begin
      state <= next_state;
    end
  end

  // First clock pulse detector after select falls
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      clock_seen <= 1'b0;
    end else if (state != sarp_pkg::sarp_wait) begin
      clock_seen <= 1'b0;
    end else if (shift_rise) begin
      clock_seen <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Conversion: one bit decision per shift clock
  // ------------------------------------------------------------
  // The comparator answer for the current trial is taken just before the
  // falling edge that shifts the decided bit out, so the result is fresh.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      result <= sarp_pkg::result_reset;
      bit_index <= sarp_pkg::bit_count_reset;
    end else if (state == sarp_pkg::sarp_idle) begin
      result <= sarp_pkg::result_reset;
      bit_index <= sarp_pkg::last_bit;
    end else if (shift_fall) begin
      case (state)
        // The null bit is already out, so the MSB decision falls here
        sarp_pkg::sarp_null, sarp_pkg::sarp_msb: begin
          // Keep trial bit when comparator says input is above
          if (!comparator_high) begin
            result <= result & ~trial_bit;
          end
          if (bit_index != 4'h0) begin
            bit_index <= bit_index - 4'h1;
          end
        end
        sarp_pkg::sarp_lsb: begin
          bit_index <= bit_index + 4'h1;
        end
        default: begin
          bit_index <= bit_index;
        end
      endcase
    end else if (state == sarp_pkg::sarp_null || state == sarp_pkg::sarp_msb) begin
      // Trial on this exchange's held sample, ahead of the decision
      result <= result | trial_bit;
    end
  end

  // ------------------------------------------------------------
  // Output pins, all from flip-flops
  // ------------------------------------------------------------
  // Data changes on falling shift clock edges, and clears to low in idle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      data_out <= 1'b0;
    end else if (state == sarp_pkg::sarp_idle) begin
      data_out <= 1'b0;
    end else if (shift_fall) begin
      case (state)
        sarp_pkg::sarp_wait: data_out <= 1'b0;
        sarp_pkg::sarp_null: data_out <= comparator_high;
        sarp_pkg::sarp_msb: data_out <= comparator_high;
        sarp_pkg::sarp_lsb: begin
          // LSB-first replay of the finished word
          data_out <= (bit_index == sarp_pkg::last_bit) ? 1'b0 : result[bit_index + 4'h1];
        end
        default: data_out <= 1'b0;
      endcase
    end
  end

  // Driver off until first clock pulse, and whenever select is high
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      data_out_enable <= 1'b0;
    end else if (!select_level || state == sarp_pkg::sarp_idle) begin
      data_out_enable <= 1'b0;
    end else if (state == sarp_pkg::sarp_wait && shift_rise) begin
      data_out_enable <= 1'b1;
    end
  end

  // Analog switch controls
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sample_enable <= 1'b1;
      hold <= 1'b0;
      negative_input_select <= 1'b0;
    end else begin
      // Sampling through idle and wait; hold from null bit on
      sample_enable <= (next_state == sarp_pkg::sarp_idle) || (next_state == sarp_pkg::sarp_wait);
      hold <= (next_state != sarp_pkg::sarp_idle) && (next_state != sarp_pkg::sarp_wait);
      negative_input_select <= (next_state != sarp_pkg::sarp_idle) && (next_state != sarp_pkg::sarp_wait);
    end
  end

  // Trial code to the DAC and done flag
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      trial_code <= sarp_pkg::result_reset;
      conversion_done <= 1'b0;
    end else begin
      trial_code <= result;
      conversion_done <= (state == sarp_pkg::sarp_lsb) || (state == sarp_pkg::sarp_done);
    end
  end

  // Shift clock level is only used for edges here
  logic unused_shift_level;
  assign unused_shift_level = shift_level;
endmodule : sarp_port

/* File: sim/sarp_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Host side: select and shift clock
// ----------------------------------------
module sarp_host_model (
  input wire logic clock,
  output logic select_n,
  output logic shift_clock,
  input wire logic data_out,
  input wire logic data_out_enable
);
  wire line = data_out_enable ? data_out : 1'bz; // Undriven line floats
  logic [31:0] bits; // Captured bits
  logic [31:0] ens; // Enable seen per bit
  initial begin
    select_n = 1'b1;
    shift_clock = 1'b0; // Clock stands low between frames
  end
  // One frame of n shift clocks, 160 ns each
  task automatic exchange(input int n);
    @(posedge clock) select_n <= 1'b0;
    repeat (4) @(posedge clock);
    for (int j = 0; j < n; j++) begin
      shift_clock <= 1'b1;
      repeat (4) @(posedge clock);
      shift_clock <= 1'b0;
      // Sample just before the next rise, after the bit settles
      repeat (4) @(posedge clock);
      bits[j] = line;
      ens[j] = data_out_enable;
    end
    select_n <= 1'b1;
  endtask : exchange
endmodule : sarp_host_model

/* File: sim/sarp_port_assertions.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module sarp_port_assertions (
  input wire logic clock,
  input wire logic reset,
  input wire logic select_n,
  input wire logic shift_clock,
  input wire logic data_out,
  input wire logic data_out_enable,
  input wire logic sample_enable,
  input wire logic hold,
  input wire logic negative_input_select,
  input wire logic conversion_done
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  off_when_idle_a: assert property (select_n [*5] |-> !data_out_enable)
    else $error("output driven while deselected");
  enable_selected_a: assert property ($rose(data_out_enable) |-> !select_n)
    else $error("output enabled without select");
  bit_on_fall_a: assert property (data_out_enable && $past(data_out_enable)
    && $changed(data_out) |-> !$past(shift_clock, 2))
    else $error("data changed off a falling shift edge");
  idle_sampling_a: assert property (select_n [*6] |-> sample_enable && !hold)
    else $error("not sampling while deselected");
  sample_hold_a: assert property (!(sample_enable && hold))
    else $error("sample and hold together");
  hold_negative_a: assert property ($rose(hold) |-> negative_input_select)
    else $error("hold without negative input");
  hold_on_fall_a: assert property ($rose(hold) |-> !$past(shift_clock, 2))
    else $error("hold not on falling edge");
  done_late_a: assert property ($rose(hold) |-> !conversion_done [*8])
    else $error("conversion finished too soon");
  release_a: assert property ($fell(data_out_enable) |-> $past(select_n, 2))
    else $error("output released while selected");
endmodule : sarp_port_assertions
bind sarp_port sarp_port_assertions chk (.clock(clock), .reset(reset), .select_n(select_n),
  .shift_clock(shift_clock), .data_out(data_out), .data_out_enable(data_out_enable),
  .sample_enable(sample_enable), .hold(hold), .negative_input_select(negative_input_select),
  .conversion_done(conversion_done));

/* File: sim/serial_adc_readout_port_tb.sv */
`timescale 1ns/1ps
module serial_adc_readout_port_tb;
  logic clock, reset, comparator_high;
  logic [11:0] vin; // Analog input as a code
  logic [11:0] trial_code;
  wire select_n, shift_clock, data_out, data_out_enable;
  wire sample_enable, hold, negative_input_select, conversion_done;
  int mismatches, checks;
  logic [26:0] exp_bits;
  sarp_port dut (.clock(clock), .reset(reset), .select_n(select_n),
    .shift_clock(shift_clock), .comparator_high(comparator_high), .data_out(data_out),
    .data_out_enable(data_out_enable), .sample_enable(sample_enable), .hold(hold),
    .negative_input_select(negative_input_select), .trial_code(trial_code),
    .conversion_done(conversion_done));
  sarp_host_model host (.clock(clock), .select_n(select_n), .shift_clock(shift_clock),
    .data_out(data_out), .data_out_enable(data_out_enable));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Ideal comparator: keep the trial bit when input reaches it
  always @(posedge clock) comparator_high <= (vin >= trial_code);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // Full frame: null, MSB-first, LSB-first from B1, then zeros
  task automatic frame_test(input logic [11:0] v);
    @(posedge clock) vin <= v;
    @(posedge clock);
    check(data_out_enable, 1'b0);
    check(sample_enable, 1'b1);
    host.exchange(27);
    exp_bits = '0;
    for (int k = 0; k < 12; k++) exp_bits[1 + k] = v[11 - k];
    for (int k = 0; k < 11; k++) exp_bits[13 + k] = v[1 + k];
    check(host.bits[26:0], exp_bits);
    check(host.ens[26:0], 27'h7ffffff);
    check(conversion_done, 1'b1);
    repeat (8) @(posedge clock);
    check(data_out_enable, 1'b0);
    check(sample_enable, 1'b1);
  endtask : frame_test
  // Cut a frame short, then a clean frame must follow
  task automatic abort_test;
    @(posedge clock) vin <= 12'h5a3;
    host.exchange(5);
    repeat (8) @(posedge clock);
    check(data_out_enable, 1'b0);
    frame_test(12'h3c6);
  endtask : abort_test
  initial begin
    reset = 1'b1;
    vin = 12'h000;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    // Back-to-back frames with changing input
    frame_test(12'h000);
    frame_test(12'hfff);
    frame_test(12'ha5c);
    frame_test(12'h001);
    frame_test(12'h800);
    abort_test();
    give_verdict();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    give_verdict();
  end
endmodule : serial_adc_readout_port_tb
